//--- hdl/modbus_tcp_request_receiver.sv
// Device end: MODBUS/TCP request receiver with offset relocation and write window
`timescale 1ns/1ps
// Notes on behaviour
// - Report each received function code
// - Unused codes are never serviced
// - Basic codes always; 16H and 17H only enhanced
// - Bit codes and word codes use different units
// - Message data only through memory word area
// - Codes map to memory or input bits/words
// - Report address; 17H fills four-word table
// - Report requested size in bits or words
// - Add selected offset words to requested address
// - Host supplies only non-negative offsets
// - Function code selects which offset applies
// - Accepted write data goes to memory words
// - Host sets zero <= low <= high <= top
// - Window check on 05,06,0B,0F,10,16,17
// - Any target outside window: error, no write
// - Channel scratch held; host clears it once
// - Raw mode stores payload bytes unconverted
// - Host selects raw variant with 2 or 3
// - Host gives each receiver distinct channel
// - Report remote unit identifier as option
module modbus_tcp_request_receiver (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Host end
  rcv_link_if.dev link,
  // Received request byte stream
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  input wire logic i_rx_last,
  // Frame status
  output logic o_rx_ready,
  output logic o_frame_done
);
  typedef enum logic [1:0] {
    ST_HEAD = 2'b00, ST_DATA = 2'b01, ST_TABLE = 2'b10, ST_DONE = 2'b11
  } state_t;

  state_t state;
  state_t next_state;
  logic [15:0] mem [rcv_pkg::MEM_DEPTH];
  logic [3:0] hcnt;
  logic [15:0] dcnt;
  logic [1:0] tcnt;
  logic [7:0] unit;
  logic [7:0] fc;
  logic [7:0] hi_byte;
  logic [15:0] addr;
  logic [15:0] size;
  logic [15:0] waddr;
  logic [15:0] wsize;
  logic [15:0] and_mask;
  logic short_frame;
  logic raw_err;
  logic take;
  logic raw;
  logic hdr_done;
  logic is_bit;
  logic [15:0] off;
  logic [15:0] eff_addr;
  logic [15:0] eff_size;
  logic [16:0] first_w;
  logic [16:0] last_w;
  logic [16:0] bit_end;
  logic win_ok;
  logic accept;
  logic wr_en;
  logic [14:0] widx;
  logic [16:0] word_tgt;
  logic [16:0] raw_tgt;
  logic raw_ok;
  logic [15:0] new_word;
  logic [16:0] bit_pos [8];
  logic [16:0] bit_word [8];

  // Byte accepted this cycle; raw selector values pick the unconverted path
  assign take = i_rx_valid && o_rx_ready;
  assign raw = link.protocol_sel == rcv_pkg::PROTO_RAW1
            || link.protocol_sel == rcv_pkg::PROTO_RAW2;
  assign hdr_done = hcnt == ((fc == rcv_pkg::FC_RW_HOLDS) ? rcv_pkg::HEAD_LAST_RW
                                                          : rcv_pkg::HEAD_LAST);
  assign new_word = {hi_byte, i_rx_data};

  // Offset chosen by function code
  always_comb begin
    case (fc)
      rcv_pkg::FC_RD_COIL, rcv_pkg::FC_WR_COIL, rcv_pkg::FC_WR_COILS:
        off = link.coil_offset;
      rcv_pkg::FC_RD_INBIT: off = link.input_relay_offset;
      rcv_pkg::FC_RD_INREG: off = link.input_register_offset;
      default: off = link.holding_register_offset;
    endcase
  end

  // Target word span; offsets are unsigned, so relocation only moves upward
  assign is_bit = rcv_pkg::is_bit_fc(fc);
  assign eff_addr = (fc == rcv_pkg::FC_RW_HOLDS) ? waddr : addr;
  assign eff_size = (fc == rcv_pkg::FC_RW_HOLDS) ? wsize
                  : (fc == rcv_pkg::FC_MASK_WR) ? 16'h0001 : size;
  assign bit_end = {1'b0, addr} + {1'b0, size};
  assign first_w = is_bit ? {1'b0, off} + {5'h00, addr[15:4]}
                          : {1'b0, off} + {1'b0, eff_addr};
  assign last_w = is_bit ? {1'b0, off} + {4'h0, bit_end[16:4]} - {4'h0, 13'(bit_end[3:0] == 4'h0)}
                         : first_w + {1'b0, eff_size} - 17'h00001;
  // Whole span must sit inside the window before anything is written
  assign win_ok = eff_size != 16'h0000 && first_w >= {1'b0, link.write_window_low}
               && last_w <= {1'b0, link.write_window_high};
  assign accept = rcv_pkg::fc_supported(fc, link.enhanced)
               && (!rcv_pkg::fc_checked(fc) || win_ok);
  assign wr_en = accept && rcv_pkg::fc_checked(fc) && !short_frame;
  assign widx = dcnt[15:1];
  assign word_tgt = first_w + {2'b00, widx};
  assign raw_tgt = {1'b0, link.write_window_low} + {2'b00, widx};
  assign raw_ok = !raw_err && raw_tgt <= {1'b0, link.write_window_high};

  // Bit position and memory word touched by each bit of a data byte
  for (genvar g = 0; g < 8; g++) begin : g_bits
    assign bit_pos[g] = {1'b0, addr} + {dcnt[13:0], 3'(g)};
    assign bit_word[g] = {1'b0, off} + {4'h0, bit_pos[g][16:4]};
  end

  // Next state
  always_comb begin
    next_state = state;
    case (state)
      ST_HEAD: begin
        if (take && i_rx_last) begin
          next_state = ST_DONE;
        end else if (take && !raw && hdr_done) begin
          next_state = ST_DATA;
        end
      end
      ST_DATA: begin
        if (take && i_rx_last) begin
          next_state = (fc == rcv_pkg::FC_RW_HOLDS && accept) ? ST_TABLE : ST_DONE;
        end
      end
      ST_TABLE: begin
        if (tcnt == rcv_pkg::TABLE_LAST) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE: next_state = ST_HEAD;
      default: next_state = ST_HEAD;
    endcase
  end

  // State register and byte acceptance
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state <= ST_HEAD;
      o_rx_ready <= 1'b0;
    end else begin
      state <= next_state;
      o_rx_ready <= next_state == ST_HEAD || next_state == ST_DATA;
    end
  end

  // Counters for header bytes, data bytes and table words
  always_ff @(posedge i_core_clk) begin
    if (i_rst || state == ST_DONE) begin
      hcnt <= 4'h0;
      dcnt <= 16'h0000;
      tcnt <= 2'h0;
    end else begin
      if (take && state == ST_HEAD && !raw) begin
        hcnt <= hcnt + 4'h1;
      end
      if (take && (state == ST_DATA || raw)) begin
        dcnt <= dcnt + 16'h0001;
      end
      if (state == ST_TABLE) begin
        tcnt <= tcnt + 2'h1;
      end
    end
  end

  // Header fields, held byte and mask
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      unit <= 8'h00;
      fc <= 8'h00;
      addr <= 16'h0000;
      size <= 16'h0000;
      waddr <= 16'h0000;
      wsize <= 16'h0000;
      hi_byte <= 8'h00;
      and_mask <= 16'h0000;
    end else if (take) begin
      hi_byte <= i_rx_data;
      if (state == ST_HEAD && !raw) begin
        case (hcnt)
          4'h0: unit <= i_rx_data;
          4'h1: fc <= i_rx_data;
          4'h2: addr[15:8] <= i_rx_data;
          4'h3: addr[7:0] <= i_rx_data;
          4'h4: size[15:8] <= i_rx_data;
          4'h5: size[7:0] <= i_rx_data;
          4'h6: waddr[15:8] <= i_rx_data;
          4'h7: waddr[7:0] <= i_rx_data;
          4'h8: wsize[15:8] <= i_rx_data;
          default: wsize[7:0] <= i_rx_data;
        endcase
      end else if (state == ST_DATA && dcnt == 16'h0001) begin
        and_mask <= new_word;
      end
    end
  end

  // Frame error flags, cleared as each frame is reported
  always_ff @(posedge i_core_clk) begin
    if (i_rst || state == ST_DONE) begin
      short_frame <= 1'b0;
      raw_err <= 1'b0;
    end else if (take) begin
      if (state == ST_HEAD && !raw && i_rx_last && !hdr_done) begin
        short_frame <= 1'b1;
      end
      if (raw && dcnt[0] && !raw_ok) begin
        raw_err <= 1'b1;
      end
    end
  end

  // Only the memory word area is ever written by a message
  always_ff @(posedge i_core_clk) begin
    if (take && state == ST_HEAD && raw && dcnt[0] && raw_ok) begin
      mem[raw_tgt[5:0]] <= new_word;
    end else if (take && state == ST_DATA && wr_en) begin
      if (is_bit) begin
        for (int j = 0; j < 8; j++) begin
          if (bit_pos[j] < bit_end) begin
            mem[bit_word[j][5:0]][bit_pos[j][3:0]] <= i_rx_data[j];
          end
        end
      end else if (fc == rcv_pkg::FC_MASK_WR) begin
        if (dcnt == 16'h0003) begin
          mem[first_w[5:0]] <= (mem[first_w[5:0]] & and_mask) | (new_word & ~and_mask);
        end
      end else if (dcnt[0] && {1'b0, widx} < eff_size) begin
        mem[word_tgt[5:0]] <= new_word;
      end
    end else if (state == ST_TABLE) begin
      case (tcnt)
        2'h0: mem[link.table_address[5:0]] <= addr;
        2'h1: mem[link.table_address[5:0] + 6'h01] <= size;
        2'h2: mem[link.table_address[5:0] + 6'h02] <= waddr;
        default: mem[link.table_address[5:0] + 6'h03] <= wsize;
      endcase
    end
  end

  // Memory read port for the host
  always_ff @(posedge i_core_clk) begin
    link.mem_rd_data <= mem[link.mem_rd_addr];
  end

  // Channel scratch: cleared by the host once, then holds the active channel
  always_ff @(posedge i_core_clk) begin
    if (i_rst || link.scratch_clear) begin
      link.channel_scratch <= 8'h00;
    end else if (take && state == ST_HEAD && hcnt == 4'h0 && dcnt == 16'h0000) begin
      link.channel_scratch <= link.channel_no;
    end
  end

  // Report each frame, accepted or not
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      link.function_code_out <= 8'h00;
      link.data_address_out <= 16'h0000;
      link.data_size_out <= 16'h0000;
      link.option_out <= 8'h00;
      link.result <= rcv_pkg::RES_OK;
      link.area <= rcv_pkg::AREA_MEM_BIT;
      link.frame_done <= 1'b0;
      o_frame_done <= 1'b0;
    end else begin
      link.frame_done <= state == ST_DONE;
      o_frame_done <= state == ST_DONE;
      if (state == ST_DONE && raw) begin
        link.function_code_out <= 8'h00;
        link.data_address_out <= link.write_window_low;
        link.data_size_out <= {1'b0, dcnt[15:1]} + {15'h0000, dcnt[0]};
        link.option_out <= 8'h00;
        link.area <= rcv_pkg::AREA_MEM_WORD;
        link.result <= raw_err ? rcv_pkg::RES_WINDOW : rcv_pkg::RES_OK;
      end else if (state == ST_DONE) begin
        link.function_code_out <= fc;
        link.data_address_out <= (fc == rcv_pkg::FC_RW_HOLDS) ? link.table_address
                                                              : addr;
        link.data_size_out <= size;
        link.option_out <= unit;
        case (fc)
          rcv_pkg::FC_RD_INBIT: link.area <= rcv_pkg::AREA_IN_BIT;
          rcv_pkg::FC_RD_INREG: link.area <= rcv_pkg::AREA_IN_WORD;
          rcv_pkg::FC_RD_COIL, rcv_pkg::FC_WR_COIL, rcv_pkg::FC_WR_COILS:
            link.area <= rcv_pkg::AREA_MEM_BIT;
          default: link.area <= rcv_pkg::AREA_MEM_WORD;
        endcase
        if (short_frame) begin
          link.result <= rcv_pkg::RES_FORMAT;
        end else if (!rcv_pkg::fc_supported(fc, link.enhanced)) begin
          link.result <= rcv_pkg::RES_BAD_FC;
        end else if (!accept) begin
          link.result <= rcv_pkg::RES_WINDOW;
        end else begin
          link.result <= rcv_pkg::RES_OK;
        end
      end
    end
  end
endmodule

//--- hdl/rcv_link_if.sv
// Link between the host configuration end and the request receiver
`timescale 1ns/1ps
interface rcv_link_if;
  // Configuration from the host
  logic [15:0] coil_offset;
  logic [15:0] input_relay_offset;
  logic [15:0] input_register_offset;
  logic [15:0] holding_register_offset;
  logic [15:0] write_window_low;
  logic [15:0] write_window_high;
  logic [15:0] table_address;
  logic [1:0] protocol_sel;
  logic enhanced;
  logic [7:0] channel_no;
  logic scratch_clear;
  logic [5:0] mem_rd_addr;
  // Results from the receiver
  logic [7:0] function_code_out;
  logic [15:0] data_address_out;
  logic [15:0] data_size_out;
  logic [7:0] option_out;
  rcv_pkg::result_t result;
  rcv_pkg::area_t area;
  logic frame_done;
  logic [7:0] channel_scratch;
  logic [15:0] mem_rd_data;

  modport dev (
    input coil_offset, input_relay_offset, input_register_offset, holding_register_offset,
    input write_window_low, write_window_high, table_address, protocol_sel, enhanced,
    input channel_no, scratch_clear, mem_rd_addr,
    output function_code_out, data_address_out, data_size_out, option_out, result, area,
    output frame_done, channel_scratch, mem_rd_data
  );
  modport host (
    output coil_offset, input_relay_offset, input_register_offset, holding_register_offset,
    output write_window_low, write_window_high, table_address, protocol_sel, enhanced,
    output channel_no, scratch_clear, mem_rd_addr,
    input function_code_out, data_address_out, data_size_out, option_out, result, area,
    input frame_done, channel_scratch, mem_rd_data
  );
endinterface

//--- hdl/rcv_pkg.sv
// Shared constants, types and decoders for the request receiver and its host end
package rcv_pkg;
  // Local memory word area
  localparam int MEM_DEPTH = 64;
  localparam int MEM_AW = 6;
  // Function codes
  localparam logic [7:0] FC_RD_COIL = 8'h01;
  localparam logic [7:0] FC_RD_INBIT = 8'h02;
  localparam logic [7:0] FC_RD_HOLD = 8'h03;
  localparam logic [7:0] FC_RD_INREG = 8'h04;
  localparam logic [7:0] FC_WR_COIL = 8'h05;
  localparam logic [7:0] FC_WR_HOLD = 8'h06;
  localparam logic [7:0] FC_WR_HOLD_EXT = 8'h0b;
  localparam logic [7:0] FC_WR_COILS = 8'h0f;
  localparam logic [7:0] FC_WR_HOLDS = 8'h10;
  localparam logic [7:0] FC_MASK_WR = 8'h16;
  localparam logic [7:0] FC_RW_HOLDS = 8'h17;
  // Protocol selector values for raw receive
  localparam logic [1:0] PROTO_RAW1 = 2'h2;
  localparam logic [1:0] PROTO_RAW2 = 2'h3;
  // Index of the last header byte, plain and read/write form, and of the last table word
  localparam logic [3:0] HEAD_LAST = 4'h5;
  localparam logic [3:0] HEAD_LAST_RW = 4'h9;
  localparam logic [1:0] TABLE_LAST = 2'h3;
  // Outcome and data area of the last request
  typedef enum logic [1:0] {
    RES_OK = 2'b00, RES_BAD_FC = 2'b01, RES_WINDOW = 2'b10, RES_FORMAT = 2'b11
  } result_t;
  typedef enum logic [1:0] {
    AREA_MEM_BIT = 2'b00, AREA_MEM_WORD = 2'b01, AREA_IN_BIT = 2'b10, AREA_IN_WORD = 2'b11
  } area_t;
  // Host register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_COIL = 8'h04;
  localparam logic [7:0] REG_RELAY = 8'h08;
  localparam logic [7:0] REG_INREG = 8'h0c;
  localparam logic [7:0] REG_HOLD = 8'h10;
  localparam logic [7:0] REG_WLOW = 8'h14;
  localparam logic [7:0] REG_WHIGH = 8'h18;
  localparam logic [7:0] REG_TABLE = 8'h1c;
  localparam logic [7:0] REG_MADDR = 8'h20;
  localparam logic [7:0] REG_MDATA = 8'h24;
  localparam logic [7:0] REG_FCODE = 8'h28;
  localparam logic [7:0] REG_ADDR = 8'h2c;
  localparam logic [7:0] REG_SIZE = 8'h30;
  localparam logic [7:0] REG_STATUS = 8'h34;
  // Control field positions, reset values and the data read from unmapped offsets
  localparam int CTRL_PROTO_LSB = 0;
  localparam int CTRL_ENH_BIT = 2;
  localparam int CTRL_CHAN_LSB = 8;
  localparam logic [15:0] CFG_RST = 16'h0000;
  localparam logic [15:0] WHIGH_RST = 16'h003f;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

  // Function codes that address bit data
  function automatic logic is_bit_fc(input logic [7:0] fc);
    return fc == FC_RD_COIL || fc == FC_RD_INBIT || fc == FC_WR_COIL || fc == FC_WR_COILS;
  endfunction

  // Codes serviced; mask and read/write forms only on the enhanced variant
  function automatic logic fc_supported(input logic [7:0] fc, input logic enh);
    case (fc)
      FC_RD_COIL, FC_RD_INBIT, FC_RD_HOLD, FC_RD_INREG: return 1'b1;
      FC_WR_COIL, FC_WR_HOLD, FC_WR_COILS, FC_WR_HOLDS: return 1'b1;
      FC_MASK_WR, FC_RW_HOLDS: return enh;
      default: return 1'b0;
    endcase
  endfunction

  // Codes whose writes are held to the write window
  function automatic logic fc_checked(input logic [7:0] fc);
    case (fc)
      FC_WR_COIL, FC_WR_HOLD, FC_WR_HOLD_EXT, FC_WR_COILS: return 1'b1;
      FC_WR_HOLDS, FC_MASK_WR, FC_RW_HOLDS: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction
endpackage

//--- hdl/receive_host_config.sv
// Host end: Avalon-MM register file that configures the receiver and reads its results
`timescale 1ns/1ps
module receive_host_config (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Avalon-MM slave
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Receiver link
  rcv_link_if.host link
);
  logic first_scan;
  logic [7:0] frame_cnt;
  logic [31:0] rd_word;

  // One wait cycle per access, then release for exactly one edge
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_avs_waitrequest <= 1'b1;
    end else begin
      o_avs_waitrequest <= !((i_avs_read || i_avs_write) && o_avs_waitrequest);
    end
  end

  // Configuration writes land at the completing edge
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      link.protocol_sel <= 2'h0;
      link.enhanced <= 1'b0;
      link.channel_no <= 8'h00;
      link.coil_offset <= rcv_pkg::CFG_RST;
      link.input_relay_offset <= rcv_pkg::CFG_RST;
      link.input_register_offset <= rcv_pkg::CFG_RST;
      link.holding_register_offset <= rcv_pkg::CFG_RST;
      link.write_window_low <= rcv_pkg::CFG_RST;
      link.write_window_high <= rcv_pkg::WHIGH_RST;
      link.table_address <= rcv_pkg::CFG_RST;
      link.mem_rd_addr <= 6'h00;
    end else if (i_avs_write && !o_avs_waitrequest) begin
      case (i_avs_address)
        rcv_pkg::REG_CTRL: begin
          link.protocol_sel <= i_avs_writedata[rcv_pkg::CTRL_PROTO_LSB +: 2];
          link.enhanced <= i_avs_writedata[rcv_pkg::CTRL_ENH_BIT];
          link.channel_no <= i_avs_writedata[rcv_pkg::CTRL_CHAN_LSB +: 8];
        end
        rcv_pkg::REG_COIL: link.coil_offset <= i_avs_writedata[15:0];
        rcv_pkg::REG_RELAY: link.input_relay_offset <= i_avs_writedata[15:0];
        rcv_pkg::REG_INREG: link.input_register_offset <= i_avs_writedata[15:0];
        rcv_pkg::REG_HOLD: link.holding_register_offset <= i_avs_writedata[15:0];
        rcv_pkg::REG_WLOW: link.write_window_low <= i_avs_writedata[15:0];
        rcv_pkg::REG_WHIGH: link.write_window_high <= i_avs_writedata[15:0];
        rcv_pkg::REG_TABLE: link.table_address <= i_avs_writedata[15:0];
        rcv_pkg::REG_MADDR: link.mem_rd_addr <= i_avs_writedata[5:0];
        default: link.coil_offset <= link.coil_offset;
      endcase
    end
  end

  // Clear the channel scratch once, in the first cycle after reset
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      first_scan <= 1'b1;
      link.scratch_clear <= 1'b0;
    end else begin
      first_scan <= 1'b0;
      link.scratch_clear <= first_scan;
    end
  end

  // Count finished frames for software polling
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      frame_cnt <= 8'h00;
    end else if (link.frame_done) begin
      frame_cnt <= frame_cnt + 8'h01;
    end
  end

  // Read decode
  always_comb begin
    case (i_avs_address)
      rcv_pkg::REG_CTRL: rd_word = {16'h0000, link.channel_no, 5'h00, link.enhanced,
                                    link.protocol_sel};
      rcv_pkg::REG_COIL: rd_word = {16'h0000, link.coil_offset};
      rcv_pkg::REG_RELAY: rd_word = {16'h0000, link.input_relay_offset};
      rcv_pkg::REG_INREG: rd_word = {16'h0000, link.input_register_offset};
      rcv_pkg::REG_HOLD: rd_word = {16'h0000, link.holding_register_offset};
      rcv_pkg::REG_WLOW: rd_word = {16'h0000, link.write_window_low};
      rcv_pkg::REG_WHIGH: rd_word = {16'h0000, link.write_window_high};
      rcv_pkg::REG_TABLE: rd_word = {16'h0000, link.table_address};
      rcv_pkg::REG_MADDR: rd_word = {26'h0000000, link.mem_rd_addr};
      rcv_pkg::REG_MDATA: rd_word = {16'h0000, link.mem_rd_data};
      rcv_pkg::REG_FCODE: rd_word = {16'h0000, link.option_out, link.function_code_out};
      rcv_pkg::REG_ADDR: rd_word = {16'h0000, link.data_address_out};
      rcv_pkg::REG_SIZE: rd_word = {16'h0000, link.data_size_out};
      rcv_pkg::REG_STATUS: rd_word = {8'h00, link.channel_scratch, frame_cnt, 4'h0,
                                      link.area, link.result};
      default: rd_word = rcv_pkg::UNMAPPED_DATA;
    endcase
  end

  // Read data is captured as waitrequest drops and stands at the completing edge
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (i_avs_read && o_avs_waitrequest) begin
      o_avs_readdata <= rd_word;
    end
  end
endmodule

//--- testbench/modbus_tcp_request_receiver_tb.sv
// Bench joining the host end and the receiver, results checked against queued notes
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; \
  if ((e) !== (g)) begin n_fail++; $display("mismatch %s expected %h seen %h", nm, e, g); end \
end
module modbus_tcp_request_receiver_tb;
  logic i_core_clk = 1'b0, i_rst = 1'b1, rd = 1'b0, wr = 1'b0, rxv = 1'b0, rxl = 1'b0;
  logic wreq, rdy, done;
  logic [7:0] adr = 8'h0, rxd = 8'h0;
  logic [31:0] wd = 32'h0, rdat, q;
  logic [15:0] w0, w1, keep;
  logic [50:0] note, expq[$];
  logic [7:0] fb[$];
  logic [7:0] bad[7] = '{8'h0, 8'h7, 8'hb, 8'he, 8'h11, 8'h15, 8'h16};
  logic [39:0] cfg[6] = '{{8'h04, 32'h2}, {8'h10, 32'h4}, {8'h14, 32'h8}, {8'h18, 32'hf},
    {8'h1c, 32'h30}, {8'h00, 32'h504}};
  int n_fail = 0, n_checks = 0, seed = 32'heefea685;
  rcv_link_if link();
  receive_host_config u_receive_host_config(.i_core_clk, .i_rst, .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wreq), .link);
  modbus_tcp_request_receiver u_modbus_tcp_request_receiver(.i_core_clk, .i_rst, .link,
    .i_rx_valid(rxv), .i_rx_data(rxd), .i_rx_last(rxl), .o_rx_ready(rdy), .o_frame_done(done));
  rcv_assertions u_rcv_assertions(.i_core_clk, .i_rst, .function_code_out(link.function_code_out),
    .data_address_out(link.data_address_out), .data_size_out(link.data_size_out),
    .result(link.result), .area(link.area), .frame_done(link.frame_done),
    .protocol_sel(link.protocol_sel), .enhanced(link.enhanced),
    .holding_register_offset(link.holding_register_offset),
    .write_window_low(link.write_window_low), .write_window_high(link.write_window_high),
    .scratch_clear(link.scratch_clear), .channel_scratch(link.channel_scratch));
  // Clock at 20 MHz
  initial forever #25 i_core_clk = ~i_core_clk;
  // Watchdog cuts a hung run short
  initial begin
    repeat (20000) @(posedge i_core_clk);
    n_fail++;
    final_report;
  end
  // Avalon access, held until waitrequest is sampled low
  task automatic av(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do @(posedge i_core_clk); while (wreq !== 1'b0);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  // Read one memory word through the host registers
  task automatic mchk(input logic [5:0] a, input logic [15:0] e);
    av(1'b1, 8'h20, {26'h0, a});
    repeat (2) @(posedge i_core_clk);
    av(1'b0, 8'h24, 32'h0);
    `CHK("memory word", {16'h0, e}, q)
  endtask
  // Send one frame, noting the results it should bring
  task automatic frame(input logic raw, input logic [7:0] fc, input logic [15:0] a, n,
    input logic [1:0] r);
    logic [7:0] u;
    u = raw ? 8'h0 : 8'($random(seed));
    if (!raw) fb = {u, fc, a[15:8], a[7:0], n[15:8], n[7:0], fb};
    expq.push_back({raw, u, fc, a, n, r});
    foreach (fb[i]) begin
      rxv <= 1'b1;
      rxd <= fb[i];
      rxl <= (i == fb.size() - 1);
      do @(posedge i_core_clk); while (rdy !== 1'b1);
    end
    rxv <= 1'b0;
    rxl <= 1'b0;
    fb = {};
    do @(posedge i_core_clk); while (done !== 1'b1);
  endtask
  // Compare each reported result with the oldest note
  always @(posedge i_core_clk) begin
    if (done === 1'b1) begin
      note = expq.pop_front();
      `CHK("function code", note[41:34], link.function_code_out)
      `CHK("unit id", note[49:42], link.option_out)
      if (!note[50]) `CHK("data address", note[33:18], link.data_address_out)
      `CHK("data size", note[17:2], link.data_size_out)
      `CHK("result", note[1:0], link.result)
    end
  end
  // Verdict
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge i_core_clk);
    i_rst <= 1'b0;
    repeat (3) @(posedge i_core_clk);
    foreach (cfg[i]) av(1'b1, cfg[i][39:32], cfg[i][31:0]);
    keep = 16'($random(seed));
    fb = {keep[15:8], keep[7:0]};
    frame(1'b0, 8'h06, 16'h6, 16'h1, 2'h0);
    mchk(6'ha, keep);
    fb = {8'h0, 8'h0};
    frame(1'b0, 8'h06, 16'h5, 16'h1, 2'h0);
    fb = {8'h01};
    frame(1'b0, 8'h05, 16'h73, 16'h1, 2'h0);
    mchk(6'h9, 16'h0008);
    av(1'b0, 8'h34, 32'h0);
    `CHK("channel scratch", 8'h05, q[23:16])
    // Top of the window filled, then spans past either bound refused
    w0 = 16'($random(seed));
    w1 = 16'($random(seed));
    fb = {w0[15:8], w0[7:0], w1[15:8], w1[7:0]};
    frame(1'b0, 8'h10, 16'ha, 16'h2, 2'h0);
    mchk(6'he, w0);
    fb = {8'h5a, 8'h5a, 8'ha5, 8'ha5};
    frame(1'b0, 8'h10, 16'hb, 16'h2, 2'h2);
    mchk(6'hf, w1);
    fb = {8'hff, 8'hff};
    frame(1'b0, 8'h06, 16'h3, 16'h1, 2'h2);
    fb = {8'hff, 8'h00, 8'h00, 8'haa};
    frame(1'b0, 8'h16, 16'ha, 16'h1, 2'h0);
    mchk(6'he, (w0 & 16'hff00) | 16'h00aa);
    // Read/write form reports the table address 30 and fills the table
    fb = {8'h0, 8'h8, 8'h0, 8'h1, w1[15:8], w1[7:0]};
    frame(1'b0, 8'h17, 16'h30, 16'h3, 2'h0);
    mchk(6'h32, 16'h0008);
    mchk(6'hc, w1);
    for (int c = 1; c < 5; c++) frame(1'b0, 8'(c), 16'h0, 16'h8, 2'h0);
    // Unused codes, and mask write with the enhanced variant off
    av(1'b1, 8'h00, 32'h500);
    foreach (bad[i]) begin
      fb = {8'h12, 8'h34};
      frame(1'b0, bad[i], 16'h6, 16'h1, 2'h1);
    end
    mchk(6'ha, keep);
    // Raw receive, both variants, stores bytes from the low bound
    for (int p = 2; p < 4; p++) begin
      av(1'b1, 8'h00, 32'(p));
      w0 = 16'($random(seed));
      fb = {w0[15:8], w0[7:0]};
      frame(1'b1, 8'h0, 16'h0, 16'h1, 2'h0);
      mchk(6'h8, w0);
    end
    av(1'b0, 8'h40, 32'h0);
    `CHK("unmapped read", 32'h0, q)
    final_report;
  end
endmodule

//--- testbench/rcv_assertions.sv
// Checker on the link between the host end and the receiver
`timescale 1ns/1ps
module rcv_assertions (
  // Clock, reset and link signals
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [7:0] function_code_out,
  input wire logic [15:0] data_address_out,
  input wire logic [15:0] data_size_out,
  input wire logic [1:0] result,
  input wire logic [1:0] area,
  input wire logic frame_done,
  input wire logic [1:0] protocol_sel,
  input wire logic enhanced,
  input wire logic [15:0] holding_register_offset,
  input wire logic [15:0] write_window_low,
  input wire logic [15:0] write_window_high,
  input wire logic scratch_clear,
  input wire logic [7:0] channel_scratch
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // Word span of a holding register request
  logic [7:0] fc;
  logic [15:0] first, last;
  assign fc = function_code_out;
  assign first = holding_register_offset + data_address_out;
  assign last = first + data_size_out - 16'h1;
  sequence s_req;
    frame_done && !protocol_sel[1];
  endsequence
  sequence s_wr;
    s_req ##0 fc inside {8'h06, 8'h10};
  endsequence
  a_unused_code: assert property (s_req ##0 fc inside {8'h0, [8'h7:8'he], [8'h11:8'h15]}
    |-> result inside {2'h1, 2'h3}) else $error("unused code serviced");
  a_enh_only: assert property (s_req ##0 !enhanced && fc inside {8'h16, 8'h17}
    |-> result != 2'h0) else $error("enhanced code serviced");
  a_area_map: assert property (s_req ##0 result == 2'h0 && fc inside {[8'h1:8'h4]}
    |-> area == {fc == 8'h2 || fc == 8'h4, fc > 8'h2}) else $error("wrong data area");
  a_done_pulse: assert property (frame_done |=> !frame_done) else $error("done too long");
  a_results_hold: assert property (!frame_done |-> $stable({fc, data_address_out}))
    else $error("results moved");
  a_window_ok: assert property (s_wr ##0 result == 2'h0 |-> first >= write_window_low
    && last <= write_window_high) else $error("write outside window");
  a_window_err: assert property (s_wr ##0 (first < write_window_low
    || last > write_window_high) |-> result == 2'h2) else $error("window not enforced");
  a_scratch_clr: assert property (scratch_clear |=> channel_scratch == 8'h0)
    else $error("scratch not cleared");
endmodule
